// ===== src/fei_pkg.sv
// constants, types and helpers for the feature element inquiry bank
package fei_pkg;
  // serial bus csr base and register offsets
  localparam logic [47:0] FEI_CSR_BASE = 48'hffff_f0f0_0000;
  localparam logic [11:0] FEI_OFS_BRIGHT = 12'h500;
  localparam logic [11:0] FEI_OFS_SHUT = 12'h51c;
  localparam logic [11:0] FEI_OFS_GAIN = 12'h520;
  localparam logic [11:0] FEI_OFS_TRIG = 12'h530;
  // flag positions, msb-first numbering
  localparam int FEI_B_PRESENCE = 0;
  localparam int FEI_B_ABS = 1;
  localparam int FEI_B_ONE_PUSH = 3;
  localparam int FEI_B_READ_OUT = 4;
  localparam int FEI_B_ON_OFF = 5;
  localparam int FEI_B_AUTO = 6;
  localparam int FEI_B_MANUAL = 7;
  localparam int FEI_B_POLARITY = 6;
  localparam int FEI_B_RAW_READ = 7;
  localparam int FEI_B_SRC0 = 8;
  localparam int FEI_B_SRC3 = 11;
  localparam int FEI_B_SW_TRIG = 15;
  localparam int FEI_B_TMODE0 = 16;
  localparam int FEI_B_TMODE1 = 17;
  // limit fields, msb-first numbering
  localparam int FEI_MIN_FIRST = 8;
  localparam int FEI_MIN_LAST = 19;
  localparam int FEI_MAX_FIRST = 20;
  localparam int FEI_MAX_LAST = 31;
  // limit values
  localparam logic [11:0] FEI_BRIGHT_MIN = 12'h000;
  localparam logic [11:0] FEI_BRIGHT_MAX = 12'h0ff;
  localparam logic [11:0] FEI_SHUT_MIN = 12'h001;
  localparam logic [11:0] FEI_SHUT_MAX_F7 = 12'hfff;
  localparam logic [11:0] FEI_SHUT_STD_MAX = 12'h800;
  localparam logic [11:0] FEI_GAIN_MIN = 12'h000;
  localparam logic [11:0] FEI_GAIN_MAX_8 = 12'h2e4;
  localparam logic [11:0] FEI_GAIN_MAX_16 = 12'h07d;
  // format seven selector and reset settings
  localparam logic [2:0] FEI_FORMAT7 = 3'h7;
  localparam logic [2:0] FEI_RST_MODE = 3'h0;
  localparam logic [2:0] FEI_RST_RATE = 3'h0;
  localparam logic [31:0] FEI_ZERO_WORD = 32'h0000_0000;

  // current video settings that steer the limits
  typedef struct packed {
    logic [2:0] format;
    logic [2:0] mode;
    logic [2:0] rate;
    logic depth16;
  } fei_cfg_t;

  localparam fei_cfg_t FEI_RST_CFG = '{FEI_FORMAT7, FEI_RST_MODE, FEI_RST_RATE, 1'b0};

  // one flag at an msb-first position
  // msb-first bit positions
  function automatic logic [31:0] fei_flag(input int pos);
    fei_flag = 32'h8000_0000 >> pos;
  endfunction : fei_flag

  // a 12-bit field whose msb-first last bit is given
  function automatic logic [31:0] fei_field(input int last, input logic [11:0] val);
    fei_field = {20'h00000, val} << (31 - last);
  endfunction : fei_field

  // flags shared by brightness, shutter and gain
  // supported flags set
  function automatic logic [31:0] fei_std_flags();
    fei_std_flags = fei_flag(FEI_B_PRESENCE) | fei_flag(FEI_B_READ_OUT) | fei_flag(FEI_B_MANUAL);
  endfunction : fei_std_flags

  // full trigger word
  function automatic logic [31:0] fei_trig_word();
    logic [31:0] w;
    w = fei_flag(FEI_B_PRESENCE) | fei_flag(FEI_B_READ_OUT) | fei_flag(FEI_B_ON_OFF);
    w = w | fei_flag(FEI_B_POLARITY) | fei_flag(FEI_B_RAW_READ) | fei_flag(FEI_B_SW_TRIG);
    for (int i = FEI_B_SRC0; i <= FEI_B_SRC3; i++) begin
      w = w | fei_flag(i);
    end
    fei_trig_word = w | fei_flag(FEI_B_TMODE0) | fei_flag(FEI_B_TMODE1);
  endfunction : fei_trig_word
endpackage : fei_pkg

// ===== src/fei_shutter_rom.sv
// lookup of the shutter upper limit for the standard formats
`timescale 1ns/1ps
module fei_shutter_rom (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [5:0] rd_addr_in,
  output logic [11:0] rd_data_out
);
  // table entry: longer frame period at lower rate codes allows a longer shutter
  function automatic logic [11:0] fei_shut_entry(input logic [5:0] idx);
    fei_shut_entry = fei_pkg::FEI_SHUT_STD_MAX >> idx[2:0];
  endfunction : fei_shut_entry

  // registered read, one cycle of latency
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_out <= 12'h000;
    end else begin
      rd_data_out <= fei_shut_entry(rd_addr_in);
    end
  end
endmodule : fei_shutter_rom

// ===== src/fei_top.sv
// feature element inquiry register bank with setting-dependent limits
`timescale 1ns/1ps
module fei_top (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [47:0] req_addr_in,
  input wire logic [31:0] req_wdata_in,
  output logic req_ready_out,
  output logic resp_valid_out,
  output logic [31:0] resp_rdata_out,
  output logic resp_err_out,
  input wire fei_pkg::fei_cfg_t cfg_in,
  output logic busy_out
);
  // refresh sequencer states
  typedef enum logic [1:0] {
    FEI_ST_IDLE,
    FEI_ST_FETCH,
    FEI_ST_LOAD
  } fei_state_t;

  fei_state_t state_r; // sequencer state
  fei_state_t state_nxt; // its next value
  fei_pkg::fei_cfg_t cfg_r; // settings the limits were built from
  logic [11:0] shut_max_r; // current shutter upper limit
  logic [11:0] gain_max_r; // current gain upper limit
  logic [11:0] rom_data; // table output
  logic cfg_changed; // inputs differ from the snapshot
  logic req_take; // request accepted this edge
  logic [31:0] word_sel; // word addressed by the request
  logic addr_hit; // request address is mapped
  logic [31:0] wr_unused; // write data, deliberately discarded

  // host writes land nowhere
  assign wr_unused = req_wdata_in;

  // full 48-bit address match against base plus offset
  function automatic logic fei_at(input logic [47:0] addr, input logic [11:0] ofs);
    fei_at = (addr == (fei_pkg::FEI_CSR_BASE + {36'h0_0000_0000, ofs}));
  endfunction : fei_at

  // brightness word is fixed
  // limit fields zero and 255
  function automatic logic [31:0] fei_bright_word();
    fei_bright_word = fei_pkg::fei_std_flags() |
      fei_pkg::fei_field(fei_pkg::FEI_MIN_LAST, fei_pkg::FEI_BRIGHT_MIN) |
      fei_pkg::fei_field(fei_pkg::FEI_MAX_LAST, fei_pkg::FEI_BRIGHT_MAX);
  endfunction : fei_bright_word

  // shared limit word builder for shutter and gain
  function automatic logic [31:0] fei_limit_word(input logic [11:0] lo, input logic [11:0] hi);
    fei_limit_word = fei_pkg::fei_std_flags() |
      fei_pkg::fei_field(fei_pkg::FEI_MIN_LAST, lo) |
      fei_pkg::fei_field(fei_pkg::FEI_MAX_LAST, hi);
  endfunction : fei_limit_word

  // gain limit follows pixel depth
  function automatic logic [11:0] fei_gain_max(input logic depth16);
    fei_gain_max = depth16 ? fei_pkg::FEI_GAIN_MAX_16 : fei_pkg::FEI_GAIN_MAX_8;
  endfunction : fei_gain_max

  // shutter table
  fei_shutter_rom u_rom (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .rd_addr_in({cfg_r.mode, cfg_r.rate}),
    .rd_data_out(rom_data)
  );

  // a settings change is only noticed while idle, so a refresh never splits
  // change detection
  assign cfg_changed = (cfg_in != cfg_r);

  // requests wait while a refresh is due or running, so no stale word escapes
  assign req_ready_out = (state_r == FEI_ST_IDLE) && !cfg_changed;
  assign req_take = req_valid_in && req_ready_out;
  assign busy_out = (state_r != FEI_ST_IDLE);

  // next state of the refresh sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // idle: start a refresh on any change
      FEI_ST_IDLE: begin
        if (cfg_changed) begin
          state_nxt = FEI_ST_FETCH;
        end
      end
      // fetch: table address settles, data comes next edge
      FEI_ST_FETCH: begin
        state_nxt = FEI_ST_LOAD;
      end
      // load: limits captured, back to serving reads
      FEI_ST_LOAD: begin
        state_nxt = FEI_ST_IDLE;
      end
      default: begin
        state_nxt = FEI_ST_IDLE;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= FEI_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // snapshot of the settings, taken when a refresh starts
  // snapshot settings
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_r <= fei_pkg::FEI_RST_CFG;
    end else if (state_r == FEI_ST_IDLE && cfg_changed) begin
      cfg_r <= cfg_in;
    end
  end

  // shutter upper limit; reset matches the format seven default
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shut_max_r <= fei_pkg::FEI_SHUT_MAX_F7;
    end else if (state_r == FEI_ST_LOAD) begin
      if (cfg_r.format == fei_pkg::FEI_FORMAT7) begin
        shut_max_r <= fei_pkg::FEI_SHUT_MAX_F7;
      end else begin
        shut_max_r <= rom_data;
      end
    end
  end

  // gain upper limit
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      gain_max_r <= fei_pkg::FEI_GAIN_MAX_8;
    end else if (state_r == FEI_ST_LOAD) begin
      gain_max_r <= fei_gain_max(cfg_r.depth16);
    end
  end

  // address decode to a word; unmapped reads as zero
  always_comb begin
    word_sel = fei_pkg::FEI_ZERO_WORD;
    addr_hit = 1'b1;
    if (fei_at(req_addr_in, fei_pkg::FEI_OFS_BRIGHT)) begin
      word_sel = fei_bright_word();
    end else if (fei_at(req_addr_in, fei_pkg::FEI_OFS_SHUT)) begin
      word_sel = fei_limit_word(fei_pkg::FEI_SHUT_MIN, shut_max_r);
    end else if (fei_at(req_addr_in, fei_pkg::FEI_OFS_GAIN)) begin
      word_sel = fei_limit_word(fei_pkg::FEI_GAIN_MIN, gain_max_r);
    end else if (fei_at(req_addr_in, fei_pkg::FEI_OFS_TRIG)) begin
      word_sel = fei_pkg::fei_trig_word();
    end else begin
      addr_hit = 1'b0;
    end
  end

  // response valid one cycle after acceptance, for reads and writes alike
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      resp_valid_out <= 1'b0;
    end else begin
      resp_valid_out <= req_take;
    end
  end

  // response data; a write answers with zero and stores nothing
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      resp_rdata_out <= fei_pkg::FEI_ZERO_WORD;
    end else if (req_take) begin
      if (req_write_in) begin
        resp_rdata_out <= fei_pkg::FEI_ZERO_WORD;
      end else begin
        resp_rdata_out <= word_sel;
      end
    end
  end

  // error flag marks an unmapped address
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      resp_err_out <= 1'b0;
    end else if (req_take) begin
      resp_err_out <= !addr_hit;
    end
  end

  // checks: refresh steps, answer timing and word contents
  sequence fei_refresh_seq;
    state_r == FEI_ST_FETCH ##1 state_r == FEI_ST_LOAD ##1 state_r == FEI_ST_IDLE;
  endsequence

  sequence fei_rd_seq(logic [11:0] ofs);
    req_take && !req_write_in && fei_at(req_addr_in, ofs);
  endsequence

  // three cycles with no request accepted: detect, fetch, load
  sequence fei_blocked_seq;
    !req_ready_out [*3];
  endsequence

  // a detected change walks fetch, then load, then idle
  refresh_walk_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (state_r == FEI_ST_IDLE && cfg_changed) |=> fei_refresh_seq)
    else $error("refresh did not run fetch then load");

  // one answer pulse per accepted request
  resp_latency_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    req_take |=> resp_valid_out ##1 !resp_valid_out || $past(req_take))
    else $error("response not one cycle after request");

  // brightness word never depends on the settings
  bright_word_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    fei_rd_seq(fei_pkg::FEI_OFS_BRIGHT) |=> resp_rdata_out == 32'h8900_00ff)
    else $error("brightness word wrong");

  // shutter flags and minimum; the maximum is watched elsewhere
  shut_low_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    fei_rd_seq(fei_pkg::FEI_OFS_SHUT) |=> resp_rdata_out[31:12] == 20'h89001)
    else $error("shutter flags or minimum wrong");

  // format seven always loads the widest limit
  shut_f7_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (state_r == FEI_ST_LOAD && cfg_r.format == 3'h7) |=> shut_max_r == 12'hfff)
    else $error("shutter limit not 4095 in format seven");

  // gain maximum follows the snapshot depth
  gain_depth_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    fei_rd_seq(fei_pkg::FEI_OFS_GAIN) |=>
      resp_rdata_out == (cfg_r.depth16 ? 32'h8900_007d : 32'h8900_02e4))
    else $error("gain word wrong for pixel depth");

  // whole trigger word, sources and modes included
  trig_word_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    fei_rd_seq(fei_pkg::FEI_OFS_TRIG) |=> resp_rdata_out == 32'h8f_f1_c0_00 >> 0)
    else $error("trigger word wrong");

  // writes leave the limits alone and answer zero
  write_ignored_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (req_take && req_write_in && state_r == FEI_ST_IDLE) |=>
      $stable(shut_max_r) && $stable(gain_max_r) && resp_rdata_out == 32'h0)
    else $error("write changed the bank");

  // holes answer with zero data
  unmapped_zero_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (resp_valid_out && resp_err_out) |-> resp_rdata_out == 32'h0)
    else $error("unmapped read returned data");

  // no request slips in while a refresh is due or running
  ready_block_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (state_r == FEI_ST_IDLE && cfg_changed) |-> fei_blocked_seq)
    else $error("request accepted during a refresh");

  // standard formats load the table entry picked by the rate code
  shut_std_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (state_r == FEI_ST_LOAD && cfg_r.format != fei_pkg::FEI_FORMAT7) |=>
      shut_max_r == (fei_pkg::FEI_SHUT_STD_MAX >> cfg_r.rate))
    else $error("shutter limit not taken from the table");

  // gain flags and a zero minimum
  gain_low_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    fei_rd_seq(fei_pkg::FEI_OFS_GAIN) |=> resp_rdata_out[31:12] == 20'h89000)
    else $error("gain flags or minimum wrong");

  // hardware sources zero to three and the software source
  trig_src_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    fei_rd_seq(fei_pkg::FEI_OFS_TRIG) |=> resp_rdata_out[23:20] == 4'hf && resp_rdata_out[16])
    else $error("trigger sources not all flagged");

  // presence sits in bit zero, the word's msb, on every mapped read
  msb_first_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (req_take && !req_write_in && addr_hit) |=> resp_rdata_out[31])
    else $error("presence flag not in the msb");

  // bit two is reserved in all four words
  reserved_zero_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (req_take && addr_hit) |=> !resp_rdata_out[29])
    else $error("reserved bit two set");
endmodule : fei_top

// ===== tb/fei_top_bench.sv
// self-checking bench for the feature element inquiry bank, with a queue-based reference model
`timescale 1ns/1ps
module fei_top_bench;
  logic sys_clk_in; // 20 MHz bench clock
  logic sys_rst_in; // async reset, active high
  logic req_valid_in, req_write_in, req_ready_out, resp_valid_out, resp_err_out, busy_out;
  logic [47:0] req_addr_in; // full serial-bus address
  logic [31:0] req_wdata_in, resp_rdata_out;
  fei_pkg::fei_cfg_t cfg_in; // video settings steering the limits
  int fails; // mismatches seen
  int samples_checked; // comparisons made
  logic [32:0] exp_q[$]; // expected {err, data} per taken request
  logic [47:0] addr_tab[5]; // four mapped words plus one hole
  fei_top dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
    .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .req_ready_out(req_ready_out), .resp_valid_out(resp_valid_out), .resp_rdata_out(resp_rdata_out),
    .resp_err_out(resp_err_out), .cfg_in(cfg_in), .busy_out(busy_out));
  // free-running clock, 50 ns period
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  // one flag at msb-first position p, written independently of the design helpers
  function automatic logic [31:0] msb_bit(input int p);
    msb_bit = 32'h0000_0001 << (31 - p);
  endfunction : msb_bit
  // reference model: the word and error flag a host must see
  function automatic logic [32:0] model(input logic wr, input logic [47:0] a, input fei_pkg::fei_cfg_t c);
    logic [31:0] std, w;
    logic e;
    std = msb_bit(0) | msb_bit(4) | msb_bit(7);
    e = 1'b0;
    w = 32'h0000_0000;
    if (a == fei_pkg::FEI_CSR_BASE + 48'h500) w = std | 32'h0000_00ff;
    else if (a == fei_pkg::FEI_CSR_BASE + 48'h51c) w = std | 32'h0000_1000 | ((c.format == 3'h7) ? 32'h0000_0fff : (32'h0000_0800 >> c.rate));
    else if (a == fei_pkg::FEI_CSR_BASE + 48'h520) w = std | (c.depth16 ? 32'h0000_007d : 32'h0000_02e4);
    else if (a == fei_pkg::FEI_CSR_BASE + 48'h530) begin
      w = std | msb_bit(5) | msb_bit(6) | msb_bit(15) | msb_bit(16) | msb_bit(17);
      for (int i = 8; i <= 11; i++) w = w | msb_bit(i);
    end else e = 1'b1;
    // writes are answered with zero data and never alter a word
    if (wr) w = 32'h0000_0000;
    model = {e, w};
  endfunction : model
  // compare a full word
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word
  // compare a single flag
  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit
  // one request, held from a falling edge until a rising edge with ready high
  task automatic req(input logic wr, input logic [47:0] a, input logic [31:0] wd);
    int n;
    @(negedge sys_clk_in);
    req_valid_in = 1'b1;
    req_write_in = wr;
    req_addr_in = a;
    req_wdata_in = wd;
    n = 0;
    #1;
    while (req_ready_out !== 1'b1 && n < 50) begin
      @(negedge sys_clk_in);
      n++;
      #1;
    end
    check_bit(req_ready_out, 1'b1);
    exp_q.push_back(model(wr, a, cfg_in));
    @(posedge sys_clk_in);
  endtask : req
  // drop the request line at the next falling edge; it stays low until the next request
  task automatic idle();
    @(negedge sys_clk_in);
    req_valid_in = 1'b0;
  endtask : idle
  // apply a setting and count refresh cycles until ready returns
  task automatic set_cfg(input fei_pkg::fei_cfg_t c, input int exp_busy);
    int nb, n;
    @(negedge sys_clk_in);
    cfg_in = c;
    nb = 0;
    n = 0;
    #1;
    while (req_ready_out !== 1'b1 && n < 20) begin
      @(negedge sys_clk_in);
      #1;
      if (busy_out === 1'b1) nb++;
      n++;
    end
    check_word(nb, exp_busy);
  endtask : set_cfg
  // response monitor: the answer pulse is looked at between its edges
  always @(negedge sys_clk_in) begin
    if (resp_valid_out === 1'b1) begin
      if (exp_q.size() == 0) check_bit(1'b1, 1'b0);
      else begin
        check_word(resp_rdata_out, exp_q[0][31:0]);
        check_bit(resp_err_out, exp_q[0][32]);
        void'(exp_q.pop_front());
      end
    end
  end
  // closing summary and verdict
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // watchdog: the sequence needs well under a thousand cycles, this allows 40000
  initial begin
    #(50 * 40000);
    fails++;
    results();
  end
  // main sequence
  initial begin
    fei_pkg::fei_cfg_t c;
    int k;
    fails = 0;
    samples_checked = 0;
    sys_rst_in = 1'b1;
    req_valid_in = 1'b0;
    req_write_in = 1'b0;
    req_addr_in = 48'h0000_0000_0000;
    req_wdata_in = 32'h0000_0000;
    cfg_in = '{3'h7, 3'h0, 3'h0, 1'b0};
    addr_tab = '{fei_pkg::FEI_CSR_BASE + 48'h500, fei_pkg::FEI_CSR_BASE + 48'h51c,
      fei_pkg::FEI_CSR_BASE + 48'h520, fei_pkg::FEI_CSR_BASE + 48'h530, fei_pkg::FEI_CSR_BASE + 48'h504};
    void'($urandom(32'h3447f2c0));
    repeat (3) @(negedge sys_clk_in);
    check_bit(resp_valid_out, 1'b0);
    check_bit(busy_out, 1'b0);
    sys_rst_in = 1'b0;
    // back-to-back reads of every word at the reset settings
    for (int i = 0; i < 5; i++) req(1'b0, addr_tab[i], 32'h0000_0000);
    // writes with random data, then read-back shows nothing changed
    for (int i = 0; i < 4; i++) req(1'b1, addr_tab[i], $urandom());
    for (int i = 0; i < 4; i++) req(1'b0, addr_tab[i], 32'h0000_0000);
    // an offset under a foreign base must not alias
    req(1'b0, 48'h0000_f0f0_0500, 32'h0000_0000);
    idle();
    // sweep standard formats and rates, then pixel depth
    for (int f = 0; f < 3; f++) begin
      for (int r = 0; r < 6; r++) begin
        set_cfg('{f[2:0], 3'h0, r[2:0], 1'b0}, 2);
        req(1'b0, addr_tab[1], 32'h0000_0000);
        idle();
      end
    end
    set_cfg('{3'h7, 3'h0, 3'h0, 1'b1}, 2);
    req(1'b0, addr_tab[2], 32'h0000_0000);
    req(1'b0, addr_tab[1], 32'h0000_0000);
    idle();
    set_cfg('{3'h7, 3'h3, 3'h0, 1'b1}, 2);
    // random settings and random traffic
    for (int i = 0; i < 200; i++) begin
      k = $urandom_range(3, 0);
      c = '{(k == 3) ? 3'h7 : k[2:0], 3'($urandom()), 3'($urandom_range(5, 0)), 1'($urandom())};
      if ($urandom_range(3, 0) == 0) begin
        idle();
        set_cfg(c, (c == cfg_in) ? 0 : 2);
      end
      req(1'($urandom()), addr_tab[$urandom_range(4, 0)], $urandom());
    end
    idle();
    // reset in mid-run restores the format seven limits
    set_cfg('{3'h0, 3'h0, 3'h2, 1'b1}, 2);
    @(negedge sys_clk_in);
    sys_rst_in = 1'b1;
    #1;
    check_bit(resp_valid_out, 1'b0);
    check_word(resp_rdata_out, 32'h0000_0000);
    @(negedge sys_clk_in);
    cfg_in = '{3'h7, 3'h0, 3'h0, 1'b0};
    @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    req(1'b0, addr_tab[1], 32'h0000_0000);
    req(1'b0, addr_tab[2], 32'h0000_0000);
    idle();
    repeat (4) @(negedge sys_clk_in);
    check_word(exp_q.size(), 0);
    results();
  end
endmodule : fei_top_bench
